// ---- mtcs_defs.vh ----
// Register indices, field positions and reset values of the main timer.
// Assumes a word-addressed bus: byte address equals index times four.
`ifndef MTCS_DEFS_VH
`define MTCS_DEFS_VH

// ----------------------------------------------------------------------
// Register indices
// ----------------------------------------------------------------------
`define MTCS_DATA_REG_A      8'h00
`define MTCS_DATA_REG_A_DIR_REG   8'h01
`define MTCS_OC1_MASK        8'h0C
`define MTCS_OC1_DATA        8'h0D
`define MTCS_FREE_COUNT      8'h0E
`define MTCS_CAPTURE_CH1     8'h10
`define MTCS_CAPTURE_CH2     8'h12
`define MTCS_CAPTURE_CH3     8'h14
`define MTCS_COMPARE_CH1     8'h16
`define MTCS_SHARED_CC_REG   8'h1E
`define MTCS_COMPARE_ACTION  8'h20
`define MTCS_CAPTURE_EDGE    8'h21
`define MTCS_TIMER_MASK1     8'h22
`define MTCS_TIMER_FLAG1     8'h23
`define MTCS_TIMER_MASK2     8'h24
`define MTCS_TIMER_FLAG2     8'h25
`define MTCS_ACCUM_CTRL      8'h26
`define MTCS_ACCUM_COUNT     8'h27
`define MTCS_WATCHDOG        8'h3A
`define MTCS_TIMER_CTRL      8'h3C

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define MTCS_CTRL_PRESCALE   1:0
`define MTCS_CTRL_RTI_RATE   3:2
`define MTCS_CTRL_WD_EN      4
`define MTCS_ACC_ENABLE      6
`define MTCS_ACC_GATED       5
`define MTCS_ACC_EDGE        4
`define MTCS_ACC_CAP4_SEL    2
`define MTCS_F2_OVERFLOW     7
`define MTCS_F2_RTI          6
`define MTCS_F2_ACC_OVF      5
`define MTCS_F2_ACC_EDGE     4

// ----------------------------------------------------------------------
// Encodings and reset values
// ----------------------------------------------------------------------
`define MTCS_EDGE_OFF        2'b00
`define MTCS_EDGE_RISE       2'b01
`define MTCS_EDGE_FALL       2'b10
`define MTCS_EDGE_ANY        2'b11
`define MTCS_ACT_NONE        2'b00
`define MTCS_ACT_TOGGLE      2'b01
`define MTCS_ACT_CLEAR       2'b10
`define MTCS_ACT_SET         2'b11
`define MTCS_RST_BYTE        8'h00
`define MTCS_RST_COMPARE     16'hFFFF
`define MTCS_RST_COUNT       16'h0000
`define MTCS_WD_KEY_ARM      8'h55
`define MTCS_WD_KEY_FIRE     8'hAA

`endif

// ---- mtcs_timer.v ----
// Main 16-bit timer: prescaler, free-running counter, captures, compares,
// pulse accumulator, periodic tick and watchdog behind an Avalon-MM slave.
// Assumes port A inputs are synchronous to clk; reset pin is open drain.
//
// Behaviour
// - Prescaler divides bus clock by 1,4,8,16
// - Counter starts at zero after reset
// - Wrap at all ones sets overflow flag
// - Software cannot load, reset or halt counter
// - Three captures, four compares, one shared channel
// - Each timer function has own interrupt request
// - Event mode counts selected accumulator input edges
// - Gated mode counts internal clock while level holds
// - Periodic interrupt at four selectable rates
// - Unserviced watchdog drives reset pin low
// - Port A bits map to channels as defined
// - Bits 3 to 0 always readable as levels
// - Compare-owned pins ignore general-purpose writes
// - Compare 1 may drive any of bits 7-3
// - Capture latches counter on configured edge
// - Edges synchronised; latch uses stable count
// - Bit 3 is compare 5 after reset
// - Bit 3 output writes trigger capture 4
// - Shared register ignores writes in capture mode
// - Edge control fields per channel, reset zero
// - Each channel independently rising, falling, any, off
// - Edge codes 00 off,01 rise,10 fall,11 any
// - Simultaneous edges capture the same count
`timescale 1ns/1ns
`include "mtcs_defs.vh"

module mtcs_timer #(
  parameter RTI_SHIFT  = 13,
  parameter WD_SHIFT   = 15,
  parameter GATE_SHIFT = 6,
  parameter WD_TICKS   = 8,
  parameter RST_HOLD   = 16
) (
  // Clock and reset
  input  wire        clk,
  input  wire        sys_rst,
  // Avalon-MM slave
  input  wire [7:0]  avs_address,
  input  wire        avs_read,
  input  wire        avs_write,
  input  wire [31:0] avs_writedata,
  output reg  [31:0] avs_readdata,
  output reg         avs_waitrequest,
  // Port A pins
  input  wire [7:0]  data_reg_a_in,
  output reg  [7:0]  data_reg_a_out_q,
  output reg  [7:0]  data_reg_a_oe_q,
  // Reset pin, open drain
  output reg         reset_pin_out_q,
  output reg         reset_pin_oe_q,
  // Interrupt requests, one per function
  output reg  [11:0] irq_req_q
);

  // --------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------
  reg  [15:0] count_q;
  reg  [3:0]  pre_cnt_q;
  reg         tick_d1_q;
  reg  [15:0] chain_q;
  reg  [7:0]  ctrl_q;
  reg  [7:0]  edge_ctl_q;
  reg  [7:0]  mask1_q;
  reg  [7:0]  flag1_q;
  reg  [7:0]  mask2_q;
  reg  [7:0]  flag2_q;
  reg  [7:0]  acc_ctl_q;
  reg  [7:0]  acc_cnt_q;
  reg  [7:0]  act_q;
  reg  [7:0]  oc1_mask_q;
  reg  [7:0]  oc1_data_q;
  reg  [7:0]  dir_q;
  reg  [15:0] cmp_q [0:3];
  reg  [15:0] shared_q;
  reg  [15:0] cap_q [0:2];
  reg  [7:0]  sync1_q;
  reg  [7:0]  sync2_q;
  reg  [7:0]  prev_q;
  reg         wd_arm_q;
  reg  [7:0]  wd_cnt_q;
  reg  [7:0]  rst_cnt_q;

  wire        cap4_sel = acc_ctl_q[`MTCS_ACC_CAP4_SEL];
  wire        wr_en    = avs_write & ~avs_waitrequest;
  wire [7:0]  wb       = avs_writedata[7:0];
  integer     i, j;

  // --------------------------------------------------------------------
  // Prescaler, counter and clock chain taps
  // --------------------------------------------------------------------
  reg  [3:0]  pre_term;
  always @* begin
    case (ctrl_q[`MTCS_CTRL_PRESCALE])
      2'b00:   pre_term = 4'h0;
      2'b01:   pre_term = 4'h3;
      2'b10:   pre_term = 4'h7;
      default: pre_term = 4'hF;
    endcase
  end
  wire        pre_tick = (pre_cnt_q >= pre_term);

  wire [4:0]  rti_span = RTI_SHIFT[4:0] + {3'b000, ctrl_q[`MTCS_CTRL_RTI_RATE]};
  wire [15:0] rti_mask = ~(16'hFFFF << rti_span);
  wire [15:0] wd_mask  = ~(16'hFFFF << WD_SHIFT);
  wire [15:0] gt_mask  = ~(16'hFFFF << GATE_SHIFT);
  wire        rti_tick = ((chain_q & rti_mask) == rti_mask);
  wire        wd_tick  = ((chain_q & wd_mask) == wd_mask);
  wire        gt_tick  = ((chain_q & gt_mask) == gt_mask);

  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      count_q   <= `MTCS_RST_COUNT;
      pre_cnt_q <= 4'h0;
      tick_d1_q <= 1'b0;
      chain_q   <= 16'h0000;
    end else begin
      chain_q   <= chain_q + 16'h0001;
      tick_d1_q <= pre_tick;
      pre_cnt_q <= pre_tick ? 4'h0 : pre_cnt_q + 4'h1;
      if (pre_tick) begin
        count_q <= count_q + 16'h0001;
      end
    end
  end

  // --------------------------------------------------------------------
  // Synchroniser and edge sources
  // --------------------------------------------------------------------
  // Driven bit 3 feeds capture 4 from its own latch
  wire [7:0]  src = {sync2_q[7:4], dir_q[3] ? data_reg_a_out_q[3] : sync2_q[3], sync2_q[2:0]};
  wire [7:0]  rise = src & ~prev_q;
  wire [7:0]  fall = ~src & prev_q;

  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sync1_q <= 8'h00;
      sync2_q <= 8'h00;
      prev_q  <= 8'h00;
    end else begin
      sync1_q <= data_reg_a_in;
      sync2_q <= sync1_q;
      prev_q  <= src;
    end
  end

  // --------------------------------------------------------------------
  // Capture and compare channels
  // --------------------------------------------------------------------
  wire [3:0]  hit;
  wire [4:0]  match;
  genvar k;
  generate
    for (k = 0; k < 4; k = k + 1) begin : g_cap
      wire [1:0] ef = edge_ctl_q[2*k+1:2*k];
      assign hit[k] = ((ef == `MTCS_EDGE_RISE) & rise[k]) |
                      ((ef == `MTCS_EDGE_FALL) & fall[k]) |
                      ((ef == `MTCS_EDGE_ANY) & (rise[k] | fall[k]));
      if (k < 3) begin : g_reg
        always @(posedge clk or posedge sys_rst) begin
          if (sys_rst) begin
            cap_q[k] <= `MTCS_RST_COUNT;
          end else if (hit[k]) begin
            cap_q[k] <= count_q;
          end
        end
      end
    end
    for (k = 0; k < 5; k = k + 1) begin : g_cmp
      if (k < 4) begin : g_oc
        assign match[k] = tick_d1_q & (count_q == cmp_q[k]);
      end else begin : g_oc5
        assign match[k] = tick_d1_q & ~cap4_sel & (count_q == shared_q);
      end
    end
  endgenerate

  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      shared_q <= `MTCS_RST_COMPARE;
      for (j = 0; j < 4; j = j + 1) begin
        cmp_q[j] <= `MTCS_RST_COMPARE;
      end
    end else begin
      for (j = 0; j < 4; j = j + 1) begin
        if (wr_en && avs_address == `MTCS_COMPARE_CH1 + 2 * j) begin
          cmp_q[j] <= avs_writedata[15:0];
        end
      end
      if (cap4_sel) begin
        if (hit[3]) begin
          shared_q <= count_q;
        end
      end else if (wr_en && avs_address == `MTCS_SHARED_CC_REG) begin
        shared_q <= avs_writedata[15:0];
      end
    end
  end

  // --------------------------------------------------------------------
  // Port A pin ownership and output latch
  // --------------------------------------------------------------------
  reg  [7:0]  own;
  reg  [7:0]  pin_d;
  reg  [1:0]  act;
  always @* begin
    own   = oc1_mask_q & 8'hF8;
    pin_d = data_reg_a_out_q;
    act   = `MTCS_ACT_NONE;
    for (i = 3; i < 7; i = i + 1) begin
      act = act_q[2*(i-3)+1 -: 2];
      if (act != `MTCS_ACT_NONE && !(i == 3 && cap4_sel)) begin
        own[i] = 1'b1;
      end
    end
    if (wr_en && avs_address == `MTCS_DATA_REG_A) begin
      pin_d = (wb & ~own) | (data_reg_a_out_q & own);
    end
    for (i = 3; i < 7; i = i + 1) begin
      act = act_q[2*(i-3)+1 -: 2];
      if (match[7-i]) begin
        case (act)
          `MTCS_ACT_TOGGLE: pin_d[i] = ~data_reg_a_out_q[i];
          `MTCS_ACT_CLEAR:  pin_d[i] = 1'b0;
          `MTCS_ACT_SET:    pin_d[i] = 1'b1;
          default:          pin_d[i] = pin_d[i];
        endcase
      end
    end
    if (match[0]) begin
      pin_d = (pin_d & ~own[7:0]) | (oc1_data_q & oc1_mask_q & 8'hF8) |
              (pin_d & own & ~oc1_mask_q);
    end
  end

  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      data_reg_a_out_q <= `MTCS_RST_BYTE;
      data_reg_a_oe_q  <= `MTCS_RST_BYTE;
    end else begin
      data_reg_a_out_q <= pin_d;
      data_reg_a_oe_q  <= (dir_q & 8'h88) | own | 8'h00;
    end
  end

  // --------------------------------------------------------------------
  // Pulse accumulator
  // --------------------------------------------------------------------
  wire        acc_en    = acc_ctl_q[`MTCS_ACC_ENABLE];
  wire        acc_gated = acc_ctl_q[`MTCS_ACC_GATED];
  wire        acc_pol   = acc_ctl_q[`MTCS_ACC_EDGE];
  wire        acc_evt   = acc_pol ? rise[7] : fall[7];
  wire        gate_on   = (src[7] != acc_pol);
  wire        gate_end  = gate_on == 1'b0 && (prev_q[7] != acc_pol);
  wire        acc_inc   = acc_en & (acc_gated ? (gate_on & gt_tick) : acc_evt);
  wire        acc_ovf   = acc_inc & (acc_cnt_q == 8'hFF);

  // --------------------------------------------------------------------
  // Flags, masks, control and watchdog
  // --------------------------------------------------------------------
  wire [7:0]  set1 = {match[0], match[1], match[2], match[3],
                      cap4_sel ? hit[3] : match[4], hit[2:0]};
  wire [7:0]  set2 = {pre_tick & (count_q == 16'hFFFF), rti_tick, acc_ovf,
                      acc_en & (acc_gated ? gate_end : acc_evt), 4'h0};
  wire        wd_fire = ctrl_q[`MTCS_CTRL_WD_EN] & wd_tick &
                        (wd_cnt_q == WD_TICKS[7:0] - 8'h01);

  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl_q     <= `MTCS_RST_BYTE;
      edge_ctl_q <= `MTCS_RST_BYTE;
      mask1_q    <= `MTCS_RST_BYTE;
      flag1_q    <= `MTCS_RST_BYTE;
      mask2_q    <= `MTCS_RST_BYTE;
      flag2_q    <= `MTCS_RST_BYTE;
      acc_ctl_q  <= `MTCS_RST_BYTE;
      acc_cnt_q  <= `MTCS_RST_BYTE;
      act_q      <= `MTCS_RST_BYTE;
      oc1_mask_q <= `MTCS_RST_BYTE;
      oc1_data_q <= `MTCS_RST_BYTE;
      dir_q      <= `MTCS_RST_BYTE;
      wd_arm_q   <= 1'b0;
      wd_cnt_q   <= 8'h00;
      rst_cnt_q  <= 8'h00;
      irq_req_q  <= 12'h000;
    end else begin
      if (wr_en) begin
        case (avs_address)
          `MTCS_TIMER_CTRL:     ctrl_q     <= wb;
          `MTCS_CAPTURE_EDGE:   edge_ctl_q <= wb;
          `MTCS_TIMER_MASK1:    mask1_q    <= wb;
          `MTCS_TIMER_MASK2:    mask2_q    <= wb & 8'hF0;
          `MTCS_ACCUM_CTRL:     acc_ctl_q  <= wb & 8'h74;
          `MTCS_COMPARE_ACTION: act_q      <= wb;
          `MTCS_OC1_MASK:       oc1_mask_q <= wb & 8'hF8;
          `MTCS_OC1_DATA:       oc1_data_q <= wb & 8'hF8;
          `MTCS_DATA_REG_A_DIR_REG:  dir_q      <= wb & 8'h88;
          default:              ctrl_q     <= ctrl_q;
        endcase
      end
      // Write one to clear; a same-cycle set wins
      flag1_q <= (flag1_q & ~((wr_en && avs_address == `MTCS_TIMER_FLAG1) ? wb : 8'h00))
                 | set1;
      flag2_q <= (flag2_q & ~((wr_en && avs_address == `MTCS_TIMER_FLAG2) ? wb : 8'h00))
                 | set2;
      if (wr_en && avs_address == `MTCS_ACCUM_COUNT) begin
        acc_cnt_q <= wb;
      end else if (acc_inc) begin
        acc_cnt_q <= acc_cnt_q + 8'h01;
      end
      irq_req_q <= {flag2_q[7:4] & mask2_q[7:4], flag1_q & mask1_q};
      // Watchdog service: arm key then fire key
      if (wr_en && avs_address == `MTCS_WATCHDOG) begin
        wd_arm_q <= (wb == `MTCS_WD_KEY_ARM);
      end
      if (wr_en && avs_address == `MTCS_WATCHDOG && wb == `MTCS_WD_KEY_FIRE && wd_arm_q) begin
        wd_cnt_q <= 8'h00;
      end else if (wd_fire) begin
        wd_cnt_q <= 8'h00;
      end else if (ctrl_q[`MTCS_CTRL_WD_EN] && wd_tick) begin
        wd_cnt_q <= wd_cnt_q + 8'h01;
      end
      if (wd_fire) begin
        rst_cnt_q <= RST_HOLD[7:0];
      end else if (rst_cnt_q != 8'h00) begin
        rst_cnt_q <= rst_cnt_q - 8'h01;
      end
    end
  end

  // --------------------------------------------------------------------
  // Reset pin drive
  // --------------------------------------------------------------------
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      reset_pin_out_q <= 1'b0;
      reset_pin_oe_q  <= 1'b0;
    end else begin
      reset_pin_out_q <= 1'b0;
      reset_pin_oe_q  <= wd_fire | (rst_cnt_q > 8'h01);
    end
  end

  // --------------------------------------------------------------------
  // Avalon-MM read mux and wait state
  // --------------------------------------------------------------------
  reg  [31:0] rd_d;
  always @* begin
    rd_d = 32'h0000_0000;
    case (avs_address)
      `MTCS_DATA_REG_A:     rd_d[7:0]  = {(data_reg_a_out_q[7:4] & dir_q[7:4]) |
                                          (sync2_q[7:4] & ~dir_q[7:4]), sync2_q[3:0]};
      `MTCS_DATA_REG_A_DIR_REG:  rd_d[7:0]  = dir_q;
      `MTCS_OC1_MASK:       rd_d[7:0]  = oc1_mask_q;
      `MTCS_OC1_DATA:       rd_d[7:0]  = oc1_data_q;
      `MTCS_FREE_COUNT:     rd_d[15:0] = count_q;
      `MTCS_CAPTURE_CH1:    rd_d[15:0] = cap_q[2];
      `MTCS_CAPTURE_CH2:    rd_d[15:0] = cap_q[1];
      `MTCS_CAPTURE_CH3:    rd_d[15:0] = cap_q[0];
      8'h16:                rd_d[15:0] = cmp_q[0];
      8'h18:                rd_d[15:0] = cmp_q[1];
      8'h1A:                rd_d[15:0] = cmp_q[2];
      8'h1C:                rd_d[15:0] = cmp_q[3];
      `MTCS_SHARED_CC_REG:  rd_d[15:0] = shared_q;
      `MTCS_COMPARE_ACTION: rd_d[7:0]  = act_q;
      `MTCS_CAPTURE_EDGE:   rd_d[7:0]  = edge_ctl_q;
      `MTCS_TIMER_MASK1:    rd_d[7:0]  = mask1_q;
      `MTCS_TIMER_FLAG1:    rd_d[7:0]  = flag1_q;
      `MTCS_TIMER_MASK2:    rd_d[7:0]  = mask2_q;
      `MTCS_TIMER_FLAG2:    rd_d[7:0]  = flag2_q;
      `MTCS_ACCUM_CTRL:     rd_d[7:0]  = acc_ctl_q;
      `MTCS_ACCUM_COUNT:    rd_d[7:0]  = acc_cnt_q;
      `MTCS_WATCHDOG:       rd_d[7:0]  = wd_cnt_q;
      `MTCS_TIMER_CTRL:     rd_d[7:0]  = ctrl_q;
      default:              rd_d       = 32'h0000_0000;
    endcase
  end

  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h0000_0000;
    end else begin
      if ((avs_read | avs_write) & avs_waitrequest) begin
        avs_waitrequest <= 1'b0;
        avs_readdata    <= rd_d;
      end else begin
        avs_waitrequest <= 1'b1;
      end
    end
  end

endmodule

// ---- mtcs_pin_model.sv ----
// Partner at the block's pins: port A lines and the open-drain reset line.
// Assumes ext_level is changed right after a rising clock edge.
`timescale 1ns/1ns

module mtcs_pin_model (
  // Outside world
  input  wire [7:0] ext_level,
  // Block side
  input  wire [7:0] data_reg_a_out_q,
  input  wire [7:0] data_reg_a_oe_q,
  output wire [7:0] data_reg_a_in,
  input  wire       reset_pin_out_q,
  input  wire       reset_pin_oe_q,
  output wire       reset_n_line
);
  // Driven bits read back the block's level
  assign data_reg_a_in = (data_reg_a_oe_q & data_reg_a_out_q) | (~data_reg_a_oe_q & ext_level);
  // Pull-up unless the block pulls low
  assign reset_n_line = reset_pin_oe_q ? reset_pin_out_q : 1'b1;
endmodule

// ---- mtcs_timer_checker.sv ----
// Port-level assertions for the main timer.
// Assumes binding to mtcs_timer; single clock domain.
`timescale 1ns/1ns

module mtcs_timer_checker #(
  parameter RST_HOLD = 16
) (
  input wire        clk,
  input wire        sys_rst,
  input wire        avs_read,
  input wire        avs_write,
  input wire [31:0] avs_readdata,
  input wire        avs_waitrequest,
  input wire [7:0]  data_reg_a_in,
  input wire        reset_pin_out_q,
  input wire        reset_pin_oe_q,
  input wire [11:0] irq_req_q
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  // ----------------------------------------------------------------
  // Reset pin hold counter
  // ----------------------------------------------------------------
  reg [7:0] hold_q;
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) hold_q <= 8'h00;
    else if (reset_pin_oe_q) hold_q <= hold_q + 8'h01;
    else hold_q <= 8'h00;
  end
  bus_answer_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus request not answered after one wait cycle");
  wait_one_a: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low longer than one cycle");
  wait_cause_a: assert property ($fell(avs_waitrequest) |-> $past(avs_read || avs_write))
    else $error("answer without request");
  read_hold_a: assert property (avs_waitrequest && !avs_read && !avs_write |=> $stable(avs_readdata))
    else $error("read data changed while idle");
  reset_low_a: assert property (reset_pin_oe_q |-> !reset_pin_out_q)
    else $error("reset pin driven high");
  reset_span_a: assert property ($fell(reset_pin_oe_q) |-> hold_q == RST_HOLD)
    else $error("reset pin hold length wrong");
  reset_end_a: assert property ($rose(reset_pin_oe_q) |-> ##[1:40] !reset_pin_oe_q)
    else $error("reset pin never released");
  capture_sync_a: assert property ($rose(irq_req_q[0]) |-> $past(data_reg_a_in[0], 2) != $past(data_reg_a_in[0], 7))
    else $error("capture request without recent pin edge");
  cover property ($rose(irq_req_q[0]));
  cover property ($rose(irq_req_q[11]));
  cover property ($fell(reset_pin_oe_q));
endmodule

// ---- test_main_timer_capture_system.sv ----
// Self-checking bench for mtcs_timer with port A partner and checker.
// Assumes the Avalon-MM slave answers after one wait cycle.
`timescale 1ns/1ns
`include "mtcs_defs.vh"

module test_main_timer_capture_system;
  reg         clk = 1'b0;
  reg         sys_rst = 1'b1;
  reg  [7:0]  avs_address = 8'h00;
  reg         avs_read = 1'b0;
  reg         avs_write = 1'b0;
  reg  [31:0] avs_writedata = 32'h0000_0000;
  reg  [7:0]  ext_level = 8'h00;
  wire [31:0] avs_readdata;
  wire        avs_waitrequest;
  wire [7:0]  data_reg_a_in;
  wire [7:0]  data_reg_a_out_q;
  wire [7:0]  data_reg_a_oe_q;
  wire        reset_pin_out_q;
  wire        reset_pin_oe_q;
  wire        reset_n_line;
  wire [11:0] irq_req_q;
  integer     fails = 0;
  integer     checks_done = 0;
  integer     cyc = 0;
  reg  [31:0] rd;
  integer     t_rd;

  mtcs_timer #(.RTI_SHIFT(3), .WD_SHIFT(4), .GATE_SHIFT(2), .WD_TICKS(2), .RST_HOLD(4)) dut_u (
    .clk(clk), .sys_rst(sys_rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .data_reg_a_in(data_reg_a_in), .data_reg_a_out_q(data_reg_a_out_q),
    .data_reg_a_oe_q(data_reg_a_oe_q), .reset_pin_out_q(reset_pin_out_q),
    .reset_pin_oe_q(reset_pin_oe_q), .irq_req_q(irq_req_q));
  mtcs_pin_model pin_u (
    .ext_level(ext_level), .data_reg_a_out_q(data_reg_a_out_q), .data_reg_a_oe_q(data_reg_a_oe_q),
    .data_reg_a_in(data_reg_a_in), .reset_pin_out_q(reset_pin_out_q),
    .reset_pin_oe_q(reset_pin_oe_q), .reset_n_line(reset_n_line));

  always #5 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;
  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task end_sim;
    begin
      $display("checks %0d mismatches %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
    end
  endtask
  task chk(input [31:0] got, input [31:0] exp);
    begin
      checks_done = checks_done + 1;
      if (got !== exp) begin
        fails = fails + 1;
        $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  task bus(input wr, input [7:0] a, input [31:0] d);
    integer n;
    begin
      n = 0;
      @(posedge clk);
      avs_address <= a;
      avs_writedata <= d;
      avs_read <= !wr;
      avs_write <= wr;
      @(posedge clk);
      while (avs_waitrequest !== 1'b0 && n < 50) begin
        @(posedge clk);
        n = n + 1;
      end
      if (n == 50) chk(32'h0000_0001, 32'h0000_0000);
      rd = avs_readdata;
      t_rd = cyc;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
    end
  endtask
  task pins(input [7:0] v);
    begin
      @(posedge clk);
      ext_level <= v;
      repeat (10) @(posedge clk);
    end
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task t_regs;
    reg [15:0] a;
    integer t0;
    begin
      bus(0, `MTCS_CAPTURE_EDGE, 0); chk(rd, 0);
      bus(0, `MTCS_SHARED_CC_REG, 0); chk(rd[15:0], `MTCS_RST_COMPARE);
      bus(0, 8'h3F, 0); chk(rd, 0);
      bus(1, `MTCS_CAPTURE_EDGE, 32'h0000_00A5);
      bus(0, `MTCS_CAPTURE_EDGE, 0); chk(rd[7:0], 8'hA5);
      bus(0, `MTCS_FREE_COUNT, 0); a = rd[15:0]; t0 = t_rd;
      chk(a < 16'h0040, 1);
      bus(1, `MTCS_FREE_COUNT, 32'h0000_F000);
      bus(0, `MTCS_FREE_COUNT, 0); chk(rd[15:0] - a, t_rd - t0);
      $display("regs done");
    end
  endtask
  task t_prescale;
    reg [15:0] a;
    integer ps, t0, e, d;
    begin
      for (ps = 0; ps < 4; ps = ps + 1) begin
        bus(1, `MTCS_TIMER_CTRL, ps);
        bus(0, `MTCS_FREE_COUNT, 0); a = rd[15:0]; t0 = t_rd;
        repeat (40) @(posedge clk);
        bus(0, `MTCS_FREE_COUNT, 0);
        d = rd[15:0] - a;
        e = (t_rd - t0) / (ps == 0 ? 1 : 2 << ps);
        chk(d == e || d == e + 1, 1);
      end
      bus(1, `MTCS_TIMER_CTRL, 0);
      $display("prescale done");
    end
  endtask
  task t_capture;
    reg [1:0] code [0:2];
    reg [2:0] er, ef;
    reg [15:0] a, c1;
    integer c, i;
    begin
      bus(1, `MTCS_TIMER_MASK1, 32'h0000_0007);
      for (c = 0; c < 4; c = c + 1) begin
        for (i = 0; i < 3; i = i + 1) begin
          code[i] = c + i;
          er[i] = code[i][0];
          ef[i] = code[i][1];
        end
        bus(1, `MTCS_CAPTURE_EDGE, {code[2], code[1], code[0]});
        bus(1, `MTCS_TIMER_FLAG1, 32'h0000_00FF);
        pins(8'h07);
        bus(0, `MTCS_TIMER_FLAG1, 0); chk(rd[2:0], er);
        chk(irq_req_q[2:0], er);
        bus(1, `MTCS_TIMER_FLAG1, 32'h0000_00FF);
        pins(8'h00);
        bus(0, `MTCS_TIMER_FLAG1, 0); chk(rd[2:0], ef);
      end
      bus(1, `MTCS_CAPTURE_EDGE, 32'h0000_003F);
      bus(0, `MTCS_FREE_COUNT, 0); a = rd[15:0];
      pins(8'h07);
      bus(0, `MTCS_CAPTURE_CH1, 0); c1 = rd[15:0];
      chk(c1 - a < 16'h0014, 1);
      bus(0, `MTCS_CAPTURE_CH2, 0); chk(rd[15:0], c1);
      bus(0, `MTCS_CAPTURE_CH3, 0); chk(rd[15:0], c1);
      pins(8'h00);
      $display("capture done");
    end
  endtask
  task t_cap4;
    begin
      bus(1, `MTCS_SHARED_CC_REG, 32'h0000_1234);
      bus(0, `MTCS_SHARED_CC_REG, 0); chk(rd[15:0], 16'h1234);
      bus(1, `MTCS_ACCUM_CTRL, 32'h0000_0004);
      bus(1, `MTCS_SHARED_CC_REG, 32'h0000_5555);
      bus(0, `MTCS_SHARED_CC_REG, 0); chk(rd[15:0], 16'h1234);
      bus(1, `MTCS_DATA_REG_A_DIR_REG, 32'h0000_0008);
      bus(1, `MTCS_CAPTURE_EDGE, 32'h0000_0040);
      bus(1, `MTCS_TIMER_FLAG1, 32'h0000_00FF);
      bus(1, `MTCS_DATA_REG_A, 32'h0000_0008);
      repeat (10) @(posedge clk);
      bus(0, `MTCS_TIMER_FLAG1, 0); chk(rd[3], 1);
      pins(8'h05);
      bus(0, `MTCS_DATA_REG_A, 0); chk(rd[3:0], 4'hD);
      bus(1, `MTCS_ACCUM_CTRL, 0);
      bus(1, `MTCS_DATA_REG_A_DIR_REG, 0);
      pins(8'h00);
      $display("capture4 done");
    end
  endtask
  task t_compare;
    reg [31:0] m;
    begin
      bus(1, `MTCS_COMPARE_ACTION, 32'h0000_00C0);
      bus(1, `MTCS_OC1_MASK, 32'h0000_0080);
      bus(1, `MTCS_OC1_DATA, 32'h0000_0080);
      bus(0, `MTCS_FREE_COUNT, 0); m = rd + 32'h0000_0020;
      bus(1, 8'h18, m);
      bus(1, `MTCS_COMPARE_CH1, m);
      repeat (40) @(posedge clk);
      chk(data_reg_a_out_q[7:6], 2'b11);
      chk(data_reg_a_oe_q[7:6], 2'b11);
      bus(1, `MTCS_DATA_REG_A, 32'h0000_0020);
      @(posedge clk);
      chk(data_reg_a_out_q[7:5], 3'b111);
      bus(1, `MTCS_OC1_MASK, 0);
      $display("compare done");
    end
  endtask
  task t_accum;
    begin
      bus(1, `MTCS_ACCUM_CTRL, 32'h0000_0050);
      pins(8'h80); pins(8'h00); pins(8'h80); pins(8'h00);
      bus(0, `MTCS_ACCUM_COUNT, 0); chk(rd[7:0], 8'h02);
      bus(1, `MTCS_ACCUM_CTRL, 32'h0000_0060);
      bus(1, `MTCS_ACCUM_COUNT, 0);
      pins(8'h80); pins(8'h00);
      bus(0, `MTCS_ACCUM_COUNT, 0); chk(rd[7:1], 7'h01);
      bus(1, `MTCS_TIMER_CTRL, 32'h0000_000C);
      bus(1, `MTCS_TIMER_FLAG2, 32'h0000_00FF);
      bus(1, `MTCS_TIMER_MASK2, 32'h0000_0040);
      wait (irq_req_q[10] === 1'b1);
      bus(1, `MTCS_TIMER_FLAG2, 32'h0000_0040);
      repeat (50) @(posedge clk);
      bus(0, `MTCS_TIMER_FLAG2, 0); chk(rd[6], 0);
      repeat (20) @(posedge clk);
      bus(0, `MTCS_TIMER_FLAG2, 0); chk(rd[6], 1);
      $display("accumulator done");
    end
  endtask
  task t_overflow;
    integer n;
    begin
      n = 0;
      bus(1, `MTCS_TIMER_MASK2, 32'h0000_0080);
      bus(1, `MTCS_TIMER_FLAG2, 32'h0000_00FF);
      while (irq_req_q[11] !== 1'b1 && n < 70000) begin
        @(posedge clk);
        n = n + 1;
      end
      bus(0, `MTCS_TIMER_FLAG2, 0); chk(rd[7], 1);
      bus(0, `MTCS_FREE_COUNT, 0); chk(rd[15:0] < 16'h0040, 1);
      $display("overflow done");
    end
  endtask
  task t_watchdog;
    integer n;
    begin
      n = 0;
      bus(1, `MTCS_TIMER_CTRL, 32'h0000_0010);
      repeat (20) begin
        bus(1, `MTCS_WATCHDOG, `MTCS_WD_KEY_ARM);
        bus(1, `MTCS_WATCHDOG, `MTCS_WD_KEY_FIRE);
      end
      chk(reset_pin_oe_q, 0);
      while (reset_pin_oe_q !== 1'b1 && n < 500) begin
        @(posedge clk);
        n = n + 1;
      end
      chk(reset_n_line, 0);
      repeat (40) @(posedge clk);
      chk(reset_n_line, 1);
      $display("watchdog done");
    end
  endtask

  initial begin
    #900_000;
    fails = fails + 1;
    end_sim;
  end
  initial begin
    repeat (6) @(posedge clk);
    sys_rst <= 1'b0;
    t_regs;
    t_prescale;
    t_capture;
    t_cap4;
    t_compare;
    t_accum;
    t_overflow;
    t_watchdog;
    end_sim;
  end
endmodule

bind mtcs_timer mtcs_timer_checker #(.RST_HOLD(RST_HOLD)) chk_u (
  .clk(clk), .sys_rst(sys_rst), .avs_read(avs_read), .avs_write(avs_write),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .data_reg_a_in(data_reg_a_in),
  .reset_pin_out_q(reset_pin_out_q), .reset_pin_oe_q(reset_pin_oe_q),
  .irq_req_q(irq_req_q));
